// *** verilog/lic_params.svh ***
// constants of the link integrity check block: offsets, fields, reset values, counts
`ifndef LIC_PARAMS_SVH
`define LIC_PARAMS_SVH

`define LIC_ADDR_CTRL 8'h00
`define LIC_ADDR_STATUS 8'h04
`define LIC_ADDR_ENH_CHECK 8'h08
`define LIC_ADDR_NORM_RESP 8'h0c
`define LIC_ADDR_IRQ_STAT 8'h10
`define LIC_ADDR_IRQ_MASK 8'h14
`define LIC_ADDR_SEED 8'h18

`define LIC_CTRL_ENC_EN 0
`define LIC_CTRL_FORCE_VID 1
`define LIC_CTRL_FORCE_AUD 2
`define LIC_CTRL_PROT_RESET 3
`define LIC_CTRL_AUTH_START 4

`define LIC_IRQ_ENH 0
`define LIC_IRQ_NORM 1
`define LIC_IRQ_AUTH 2
`define LIC_IRQ_BITS 3

`define LIC_ENH_PERIOD 5'h10
`define LIC_NORM_PERIOD 8'h80
`define LIC_SEED_RESET 32'h0000_0001
`define LIC_FORCE_VID_VALUE 24'h0000ff
`define LIC_FORCE_AUD_VALUE 32'h0000_0000

`endif

// *** verilog/lic_pkg.sv ***
// types of the link integrity check block
package lic_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} lic_apb_req_type;

	typedef struct packed {
		logic [23:0] video;
		logic [31:0] audio;
		logic vsync;
	} lic_av_type;

	typedef enum logic [1:0] {
		LIC_WAIT_AUTH = 2'b00,
		LIC_AUTHENTICATING = 2'b01,
		LIC_AUTHENTICATED = 2'b10
	} lic_state_type;
endpackage

// *** verilog/lic_keystream.sv ***
// keystream register stepped while encrypting; stands in for the cipher core
`include "lic_params.svh"
module lic_keystream (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic step_in,
	input wire logic [31:0] seed_in,
	output logic [31:0] state_out
);
	logic [31:0] state_r;
	logic [31:0] state_nxt;

	always_comb begin
		state_nxt = state_r;
		if (load_in) begin
			state_nxt = (seed_in == 32'h0) ? `LIC_SEED_RESET : seed_in;
		end else if (step_in) begin
			state_nxt = {state_r[30:0], state_r[31] ^ state_r[21] ^ state_r[1] ^ state_r[0]};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r <= `LIC_SEED_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign state_out = state_r;
endmodule

// *** verilog/lic_link_check.sv ***
// serializer link integrity logic: check words, encryption gate, authentication wait, apb registers
`include "lic_params.svh"
module lic_link_check (
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	input wire lic_pkg::lic_apb_req_type APB_REQ_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire lic_pkg::lic_av_type AV_IN,
	input wire logic AUTH_DONE_IN,
	output lic_pkg::lic_av_type AV_OUT,
	output logic ENCRYPTING_OUT,
	output logic AUTH_BUSY_OUT,
	output logic IRQ_OUT
);
	import lic_pkg::*;

	lic_state_type state_r, state_nxt;
	logic enc_en_r, enc_en_nxt;
	logic force_vid_r, force_vid_nxt;
	logic force_aud_r, force_aud_nxt;
	logic [31:0] seed_r, seed_nxt;
	logic [7:0] enhanced_check_word_r, enhanced_check_word_nxt;
	logic [15:0] normal_integrity_response_r, normal_integrity_response_nxt;
	logic [`LIC_IRQ_BITS-1:0] irq_stat_r, irq_stat_nxt;
	logic [`LIC_IRQ_BITS-1:0] irq_mask_r, irq_mask_nxt;
	logic irq_r, irq_nxt;
	logic [3:0] enh_cnt_r, enh_cnt_nxt;
	logic [6:0] norm_cnt_r, norm_cnt_nxt;
	logic vsync_d_r, vsync_d_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	lic_av_type av_r, av_nxt;
	logic encrypting_r, encrypting_nxt;
	logic busy_r, busy_nxt;

	logic access;
	logic wr_done;
	logic rd_done;
	logic enc_active;
	logic frame_tick;
	logic enc_rise;
	logic ks_load;
	logic [31:0] ks;
	logic [31:0] rd_mux;
	logic mapped;
	logic [`LIC_IRQ_BITS-1:0] events;

	// apb: one wait state, the access completes on the edge where pready_r is high
	assign access = APB_REQ_IN.psel && APB_REQ_IN.penable;
	assign wr_done = access && pready_r && APB_REQ_IN.pwrite;
	assign rd_done = access && pready_r && !APB_REQ_IN.pwrite;
	assign enc_active = enc_en_r && (state_r == LIC_AUTHENTICATED);
	assign frame_tick = AV_IN.vsync && !vsync_d_r;
	assign enc_rise = enc_active && !encrypting_r;
	// keystream restarts from the seed at each new authentication
	assign ks_load = (state_r == LIC_AUTHENTICATING) && AUTH_DONE_IN;

	lic_keystream u_keystream (
		.clk_in(REF_CLK_IN),
		.rst_n_in(RST_N_IN),
		.load_in(ks_load),
		.step_in(enc_active),
		.seed_in(seed_r),
		.state_out(ks)
	);

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0;
		unique case (APB_REQ_IN.paddr)
			`LIC_ADDR_CTRL: rd_mux = {27'h0, 2'b00, force_aud_r, force_vid_r, enc_en_r};
			`LIC_ADDR_STATUS: rd_mux = {28'h0, busy_r, encrypting_r, state_r};
			`LIC_ADDR_ENH_CHECK: rd_mux = {24'h0, enhanced_check_word_r};
			`LIC_ADDR_NORM_RESP: rd_mux = {16'h0, normal_integrity_response_r};
			`LIC_ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
			`LIC_ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
			`LIC_ADDR_SEED: rd_mux = seed_r;
			default: mapped = 1'b0;
		endcase
	end

	// bus slave and software-written state
	always_comb begin
		pready_nxt = access && !pready_r;
		pslverr_nxt = access && !pready_r && !mapped;
		prdata_nxt = (access && !pready_r && !APB_REQ_IN.pwrite) ? rd_mux : 32'h0;
		enc_en_nxt = enc_en_r;
		force_vid_nxt = force_vid_r;
		force_aud_nxt = force_aud_r;
		seed_nxt = seed_r;
		irq_mask_nxt = irq_mask_r;
		if (wr_done) begin
			unique case (APB_REQ_IN.paddr)
				`LIC_ADDR_CTRL: begin
					enc_en_nxt = APB_REQ_IN.pwdata[`LIC_CTRL_ENC_EN];
					force_vid_nxt = APB_REQ_IN.pwdata[`LIC_CTRL_FORCE_VID];
					force_aud_nxt = APB_REQ_IN.pwdata[`LIC_CTRL_FORCE_AUD];
				end
				`LIC_ADDR_IRQ_MASK: irq_mask_nxt = APB_REQ_IN.pwdata[`LIC_IRQ_BITS-1:0];
				`LIC_ADDR_SEED: seed_nxt = APB_REQ_IN.pwdata;
				default: ;
			endcase
		end
	end

	// authentication sequencing; the handshake itself lives outside this block
	always_comb begin
		state_nxt = state_r;
		busy_nxt = 1'b0;
		if (wr_done && (APB_REQ_IN.paddr == `LIC_ADDR_CTRL)
				&& APB_REQ_IN.pwdata[`LIC_CTRL_PROT_RESET]) begin
			state_nxt = LIC_WAIT_AUTH;
		end else begin
			unique case (state_r)
				LIC_WAIT_AUTH: begin
					// start is honoured only from the waiting state, so reset must come first
					if (wr_done && (APB_REQ_IN.paddr == `LIC_ADDR_CTRL)
							&& APB_REQ_IN.pwdata[`LIC_CTRL_AUTH_START]) begin
						state_nxt = LIC_AUTHENTICATING;
					end
				end
				LIC_AUTHENTICATING: begin
					if (AUTH_DONE_IN) begin
						state_nxt = LIC_AUTHENTICATED;
					end
				end
				LIC_AUTHENTICATED: ;
				default: state_nxt = LIC_WAIT_AUTH;
			endcase
		end
		busy_nxt = (state_nxt == LIC_AUTHENTICATING);
	end

	// check-word cadence
	always_comb begin
		vsync_d_nxt = AV_IN.vsync;
		encrypting_nxt = enc_active;
		enh_cnt_nxt = enh_cnt_r;
		norm_cnt_nxt = norm_cnt_r;
		enhanced_check_word_nxt = enhanced_check_word_r;
		normal_integrity_response_nxt = normal_integrity_response_r;
		events = '0;
		if (enc_rise) begin
			enh_cnt_nxt = 4'h0;
			norm_cnt_nxt = 7'h0;
		end else if (enc_active && frame_tick) begin
			enh_cnt_nxt = enh_cnt_r + 4'h1;
			norm_cnt_nxt = norm_cnt_r + 7'h1;
			// the 4-bit count wraps after the 16th frame sync
			if (enh_cnt_r == 4'(`LIC_ENH_PERIOD - 5'h1)) begin
				enhanced_check_word_nxt = ks[7:0] ^ ks[23:16];
				events[`LIC_IRQ_ENH] = 1'b1;
			end
			if (norm_cnt_r == 7'(`LIC_NORM_PERIOD - 8'h1)) begin
				normal_integrity_response_nxt = ks[31:16] ^ ks[15:0];
				events[`LIC_IRQ_NORM] = 1'b1;
			end
		end
		events[`LIC_IRQ_AUTH] = ks_load;
	end

	// sticky status cleared by reading it; a new event in that cycle wins
	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (rd_done && (APB_REQ_IN.paddr == `LIC_ADDR_IRQ_STAT)) begin
			irq_stat_nxt = '0;
		end
		irq_stat_nxt = irq_stat_nxt | events;
		irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
	end

	// data path: never stalled by check-word work, only masked or scrambled
	always_comb begin
		av_nxt = AV_IN;
		if (force_vid_r) begin
			av_nxt.video = `LIC_FORCE_VID_VALUE;
		end else if (enc_active) begin
			av_nxt.video = AV_IN.video ^ ks[23:0];
		end
		if (force_aud_r) begin
			av_nxt.audio = `LIC_FORCE_AUD_VALUE;
		end else if (enc_active) begin
			av_nxt.audio = AV_IN.audio ^ {ks[15:0], ks[31:16]};
		end
		// with enable cleared or unauthenticated, content passes unencrypted
		if (!enc_active) begin
			av_nxt.video = force_vid_r ? `LIC_FORCE_VID_VALUE : AV_IN.video;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_N_IN) begin
			state_r <= LIC_WAIT_AUTH;
			enc_en_r <= 1'b0;
			force_vid_r <= 1'b0;
			force_aud_r <= 1'b0;
			seed_r <= `LIC_SEED_RESET;
			enhanced_check_word_r <= 8'h00;
			normal_integrity_response_r <= 16'h0000;
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_r <= 1'b0;
			enh_cnt_r <= 4'h0;
			norm_cnt_r <= 7'h00;
			vsync_d_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			av_r <= '0;
			encrypting_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			enc_en_r <= enc_en_nxt;
			force_vid_r <= force_vid_nxt;
			force_aud_r <= force_aud_nxt;
			seed_r <= seed_nxt;
			enhanced_check_word_r <= enhanced_check_word_nxt;
			normal_integrity_response_r <= normal_integrity_response_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r <= irq_nxt;
			enh_cnt_r <= enh_cnt_nxt;
			norm_cnt_r <= norm_cnt_nxt;
			vsync_d_r <= vsync_d_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
			av_r <= av_nxt;
			encrypting_r <= encrypting_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign PRDATA_OUT = prdata_r;
	assign PREADY_OUT = pready_r;
	assign PSLVERR_OUT = pslverr_r;
	assign AV_OUT = av_r;
	assign ENCRYPTING_OUT = encrypting_r;
	assign AUTH_BUSY_OUT = busy_r;
	assign IRQ_OUT = irq_r;
endmodule

// *** sim/lic_link_check_chk.sv ***
// port checker of the link integrity block
`include "lic_params.svh"
module lic_link_check_chk (
	input wire logic REF_CLK_IN,
	input wire logic RST_N_IN,
	input wire lic_pkg::lic_apb_req_type APB_REQ_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire lic_pkg::lic_av_type AV_IN,
	input wire logic AUTH_DONE_IN,
	input wire lic_pkg::lic_av_type AV_OUT,
	input wire logic ENCRYPTING_OUT,
	input wire logic AUTH_BUSY_OUT,
	input wire logic IRQ_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import lic_pkg::*;
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	AST_READY_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("pready held");
	AST_READY_WAIT: assert property (APB_REQ_IN.psel && APB_REQ_IN.penable && !PREADY_OUT
		|=> PREADY_OUT) else $error("pready late");
	AST_RDATA_IDLE: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
		else $error("prdata outside access");
	AST_ERR_READY: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("pslverr alone");
	AST_ENC_IDLE: assert property (AUTH_BUSY_OUT |-> !ENCRYPTING_OUT)
		else $error("encrypting while authenticating");
	AST_ENC_CAUSE: assert property ($rose(ENCRYPTING_OUT) |->
		$past(AUTH_DONE_IN, 2) || $past(PREADY_OUT, 2) || $past(PREADY_OUT, 3))
		else $error("encryption without cause");
	AST_VSYNC_PASS: assert property ($past(RST_N_IN) |->
		AV_OUT.vsync == $past(AV_IN.vsync)) else $error("frame sync broken");
	AST_PLAIN_PASS: assert property ($past(RST_N_IN) && !ENCRYPTING_OUT &&
		!$past(ENCRYPTING_OUT) |-> AV_OUT.video == $past(AV_IN.video) ||
		AV_OUT.video == `LIC_FORCE_VID_VALUE) else $error("plain video altered");
	AST_IRQ_FALL: assert property ($fell(IRQ_OUT) |->
		$past(PREADY_OUT) || $past(PREADY_OUT, 2) || $past(PREADY_OUT, 3))
		else $error("irq dropped without access");
	AST_AUTH_END: assert property ($fell(AUTH_BUSY_OUT) |->
		$past(AUTH_DONE_IN) || $past(AUTH_DONE_IN, 2) || $past(AUTH_DONE_IN, 3))
		else $error("authentication ended early");
endmodule

// *** sim/lic_far_model.sv ***
// far side model: authentication engine answer and deserializer frame cadence
module lic_far_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic busy_in,
	input wire logic enc_in,
	input wire lic_pkg::lic_av_type av_in,
	input wire logic [7:0] dly_in,
	output logic done_out,
	output logic [7:0] ticks_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import lic_pkg::*;
	logic [7:0] wait_r, wait_nxt, ticks_nxt;
	logic [4:0] frm_r, frm_nxt;
	logic vs_r, enc_r;
	logic relay_r, relay_wr_r, relay_ack;
	// relay flag of the repeater input deserializer: the write is resent until acknowledged
	assign relay_ack = relay_wr_r;
	// one pulse only: the wait count runs past the delay if busy lingers;
	// authentication cannot complete before the relay flag is in place
	assign done_out = relay_r && busy_in && wait_r == dly_in;
	always_comb begin
		wait_nxt = busy_in ? wait_r + 8'h01 : 8'h00;
		frm_nxt = frm_r;
		ticks_nxt = ticks_out;
		if (enc_in && !enc_r) frm_nxt = 5'h00;
		else if (enc_in && av_in.vsync && !vs_r) frm_nxt = frm_r + 5'h01;
		if (frm_nxt == 5'h10) begin
			frm_nxt = 5'h00;
			ticks_nxt = ticks_out + 8'h01;
		end
	end
	always_ff @(posedge clk_in) begin
		wait_r <= rst_n_in ? wait_nxt : 8'h00;
		frm_r <= rst_n_in ? frm_nxt : 5'h00;
		ticks_out <= rst_n_in ? ticks_nxt : 8'h00;
		vs_r <= rst_n_in && av_in.vsync;
		enc_r <= rst_n_in && enc_in;
		relay_wr_r <= rst_n_in && !relay_r;
		relay_r <= rst_n_in && (relay_r || relay_ack);
	end
endmodule

// *** sim/link_integrity_check_seq_tb.sv ***
// self-checking bench of the link integrity block
`include "lic_params.svh"
module link_integrity_check_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lic_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic er;
	} lic_row_type;
	lic_row_type rows [12] = '{'{0, `LIC_ADDR_CTRL, 0, 0, 0}, '{0, `LIC_ADDR_ENH_CHECK, 0, 0, 0},
		'{0, `LIC_ADDR_NORM_RESP, 0, 0, 0}, '{0, `LIC_ADDR_IRQ_STAT, 0, 0, 0},
		'{0, `LIC_ADDR_IRQ_MASK, 0, 0, 0}, '{0, `LIC_ADDR_SEED, 0, `LIC_SEED_RESET, 0},
		'{1, `LIC_ADDR_SEED, 0, 0, 0}, '{0, `LIC_ADDR_SEED, 0, 32'h0, 0},
		'{1, `LIC_ADDR_STATUS, 32'hf, 0, 0}, '{0, `LIC_ADDR_STATUS, 0, 0, 0},
		'{0, 8'h1c, 0, 0, 1}, '{1, 8'h1c, 32'h5, 0, 1}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	lic_apb_req_type req = '0;
	lic_av_type av = '0;
	lic_av_type avo;
	logic [31:0] rdata, rd;
	logic rdy, err, er, done, enc, busy, irq;
	logic [7:0] dly = 8'h02;
	logic [7:0] ticks;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	int miss;
	logic [7:0] pj;
	always #2 clk = ~clk;
	lic_link_check DUT (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .APB_REQ_IN(req),
		.PRDATA_OUT(rdata), .PREADY_OUT(rdy), .PSLVERR_OUT(err), .AV_IN(av),
		.AUTH_DONE_IN(done), .AV_OUT(avo), .ENCRYPTING_OUT(enc), .AUTH_BUSY_OUT(busy),
		.IRQ_OUT(irq));
	lic_far_model u_far (.clk_in(clk), .rst_n_in(rst_n), .busy_in(busy), .enc_in(enc),
		.av_in(avo), .dly_in(dly), .done_out(done), .ticks_out(ticks));
	task automatic final_report();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch %0t %s", $time, msg);
		end
	endtask
	// outputs read at the edge still show what the previous edge registered
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		rd = rdata;
		er = err;
		check(rdy === 1'b1, "no pready");
		req <= '0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0);
		check(rd === e, m);
	endtask
	// controller side: local word against the remote one, retried after a mismatch
	task automatic pj_compare(input logic [7:0] remote, output int miss_out);
		miss_out = 0;
		do begin
			apb(1'b0, `LIC_ADDR_ENH_CHECK, 32'h0);
			if (rd[7:0] !== remote) miss_out++;
		end while (miss_out > 0 && miss_out < 3);
	endtask
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge clk);
			av.vsync <= 1'b1;
			av.video <= av.video + 24'h000011;
			av.audio <= av.audio + 32'h0000_0101;
			repeat (2) @(posedge clk);
			av.vsync <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic wait_enc(input logic want);
		int n;
		n = 0;
		while (enc !== want && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(enc === want, "encrypting level");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		check(enc === 1'b0 && busy === 1'b0, "busy after reset");
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			check(er === rows[i].er && (rows[i].wr || rd === rows[i].e), "reg row");
		end
		apb(1'b1, `LIC_ADDR_IRQ_MASK, 32'h7);
		apb(1'b1, `LIC_ADDR_CTRL, 32'h11);
		wait_enc(1'b1);
		rdchk(`LIC_ADDR_IRQ_STAT, 32'h4, "auth event");
		rdchk(`LIC_ADDR_IRQ_STAT, 32'h0, "read clear");
		rdchk(`LIC_ADDR_STATUS, 32'h6, "status encrypting");
		frames(15);
		check(irq === 1'b0, "early update");
		frames(1);
		check(irq === 1'b1 && ticks === 8'h01, "no update at 16");
		// a deserializer in step holds the same word for the whole interval
		apb(1'b0, `LIC_ADDR_ENH_CHECK, 32'h0);
		pj = rd[7:0];
		pj_compare(pj, miss);
		check(miss == 0, "check word not steady");
		pj_compare(~pj, miss);
		check(miss == 3, "failure before three mismatches");
		frames(112);
		rdchk(`LIC_ADDR_IRQ_STAT, 32'h3, "updates at 128");
		check(ticks === 8'h08, "remote cadence");
		apb(1'b1, `LIC_ADDR_CTRL, 32'h7);
		repeat (2) @(posedge clk);
		check(avo.video === `LIC_FORCE_VID_VALUE && avo.audio === 32'h0, "not masked");
		apb(1'b1, `LIC_ADDR_CTRL, 32'h0);
		wait_enc(1'b0);
		@(posedge clk);
		check(avo === av, "content altered");
		frames(16);
		rdchk(`LIC_ADDR_IRQ_STAT, 32'h0, "update while off");
		apb(1'b1, `LIC_ADDR_CTRL, 32'h10);
		rdchk(`LIC_ADDR_STATUS, 32'h2, "start taken late");
		dly <= 8'h14;
		apb(1'b1, `LIC_ADDR_CTRL, 32'h08);
		rdchk(`LIC_ADDR_STATUS, 32'h0, "not back to wait");
		apb(1'b1, `LIC_ADDR_CTRL, 32'h10);
		rdchk(`LIC_ADDR_STATUS, 32'h9, "not authenticating");
		apb(1'b1, `LIC_ADDR_CTRL, 32'h1);
		wait_enc(1'b1);
		frames(10);
		apb(1'b1, `LIC_ADDR_CTRL, 32'h0);
		wait_enc(1'b0);
		apb(1'b1, `LIC_ADDR_CTRL, 32'h1);
		wait_enc(1'b1);
		frames(10);
		rdchk(`LIC_ADDR_IRQ_STAT, 32'h4, "count not restarted");
		apb(1'b1, `LIC_ADDR_IRQ_MASK, 32'h0);
		frames(6);
		check(irq === 1'b0, "masked irq");
		rdchk(`LIC_ADDR_IRQ_STAT, 32'h1, "update at 16 after restart");
		final_report();
	end
endmodule
bind lic_link_check lic_link_check_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
	.APB_REQ_IN(APB_REQ_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .AV_IN(AV_IN), .AUTH_DONE_IN(AUTH_DONE_IN), .AV_OUT(AV_OUT),
	.ENCRYPTING_OUT(ENCRYPTING_OUT), .AUTH_BUSY_OUT(AUTH_BUSY_OUT), .IRQ_OUT(IRQ_OUT));
